// *** core/tcpwm_pkg.sv ***
// Package for the five-channel timer/counter/PWM unit: register map, fields, reset values.
// Assumes a 32-bit APB register bus; every register is one aligned word.
package tcpwm_pkg;
  localparam int unsigned NUM_CH     = 5;
  localparam int unsigned CNT_W      = 16;
  // Per-channel window of 8 words; channel n at n*0x20
  localparam logic [11:0] CH_STRIDE  = 12'h020;
  localparam logic [4:0]  OFF_CTRL   = 5'h00;
  localparam logic [4:0]  OFF_PERIOD = 5'h04;
  localparam logic [4:0]  OFF_CMP    = 5'h08;
  localparam logic [4:0]  OFF_DEAD   = 5'h0c;
  localparam logic [4:0]  OFF_COUNT  = 5'h10;
  localparam logic [4:0]  OFF_CAPT   = 5'h14;
  localparam logic [4:0]  OFF_STAT   = 5'h18;
  // Control fields
  localparam int unsigned CTRL_EN     = 0;
  localparam int unsigned CTRL_ONE    = 1;
  localparam int unsigned CTRL_CAPEN  = 2;
  localparam int unsigned CTRL_KLVL   = 3;
  localparam int unsigned CTRL_KLVLC  = 4;
  localparam int unsigned CTRL_W      = 5;
  localparam logic [4:0]  CTRL_RST    = 5'h00;
  localparam logic [15:0] PERIOD_RST  = 16'hffff;
  localparam logic [15:0] CMP_RST     = 16'h0000;
  localparam logic [7:0]  DEAD_RST    = 8'h00;

  typedef struct packed {
    logic line;
    logic line_compl;
  } tcpwm_pair_s;
endpackage

// *** core/tcpwm_unit.sv ***
// Five independent 16-bit timer/counter/PWM channels behind one APB slave.
// Assumes capture and kill inputs are already synchronous to pclk.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps

// Functional notes
// - Each channel has a 16-bit counter whose period is set by a software period value.
// - A capture event, possibly from a pin, copies the current count into the capture register.
// - On count equal to period the counter stops in one-shot mode or reloads to zero otherwise.
// - The counter is compared with a programmed compare value to set the PWM duty cycle.
// - A true and a complementary output are driven, with a programmable dead band between edges.
// - An active kill input forces both outputs to a programmed preset level at once.
// - Five independent copies of the channel exist.
module tcpwm_unit (
  input  wire logic                      pclk,        // 100 MHz bus clock
  input  wire logic                      presetn,     // Async reset, active low
  input  wire logic                      psel,        // APB select
  input  wire logic                      penable,     // APB access phase
  input  wire logic                      pwrite,      // APB write
  input  wire logic [11:0]               paddr,       // APB byte address
  input  wire logic [31:0]               pwdata,      // APB write data
  output logic      [31:0]               prdata,      // APB read data
  output logic                           pready,      // APB ready
  output logic                           pslverr,     // APB error on unmapped address
  input  wire logic [tcpwm_pkg::NUM_CH-1:0] capture_in, // Capture event, rising edge
  input  wire logic [tcpwm_pkg::NUM_CH-1:0] kill_in,    // Shutdown, active high
  output tcpwm_pkg::tcpwm_pair_s [tcpwm_pkg::NUM_CH-1:0] pwm_out // True/compl pair
);
  localparam int unsigned N = tcpwm_pkg::NUM_CH;
  localparam int unsigned W = tcpwm_pkg::CNT_W;

  // Address decode
  // Bits 7:5 pick the channel and bits 4:0 the word inside its window.
  // Anything above bit 7, a channel past the last one, a word past the
  // status word or a byte lane offset is refused with pslverr.
  // A refused write changes nothing, and a refused read returns zero,
  // so software probing the map sees a clean hole rather than an alias.
  // The decode is purely combinational, which is why no wait state is
  // ever needed: the answer is known in the setup cycle already.

  logic [2:0] ch_sel;
  logic [4:0] reg_off;
  logic       ch_ok;
  logic       wr_acc;
  assign ch_sel  = paddr[7:5];
  assign reg_off = paddr[4:0];
  assign ch_ok   = (paddr[11:8] == 4'h0) && (ch_sel < 3'(N)) && (paddr[1:0] == 2'b00)
                   && (reg_off <= tcpwm_pkg::OFF_STAT);
  assign wr_acc  = psel && penable && pwrite && ch_ok;
  // Zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !ch_ok;


  // Per-channel state, one packed entry per channel
  // The arrays are indexed by the channel number; each generate pass
  // writes only its own entry, so there is still one driver per bit.
  // The read mux below indexes them with the decoded channel number,
  // which is only used once the decode has accepted the address.
  logic [N-1:0][tcpwm_pkg::CTRL_W-1:0] ctrl;
  logic [N-1:0][W-1:0]                 period;
  logic [N-1:0][W-1:0]                 cmp;
  logic [N-1:0][7:0]                   dead;
  logic [N-1:0][W-1:0]                 count;
  logic [N-1:0][W-1:0]                 capt;
  logic [N-1:0]                        running;
  logic [N-1:0]                        capt_flag;
  logic [N-1:0]                        cap_prev;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      // One channel: register file, counter, capture, dead band, kill.
      // Channels share nothing but the bus, so a fault or a kill on one
      // leaves the others running undisturbed.
      logic       sel_w;
      logic       cap_evt;
      logic       pwm_raw;
      logic       raw_prev;
      logic [7:0] dt_cnt;
      logic       dly_true;
      logic       dly_compl;
      assign sel_w   = wr_acc && (ch_sel == 3'(g));
      assign cap_evt = capture_in[g] && !cap_prev[g] && ctrl[g][tcpwm_pkg::CTRL_CAPEN];
      assign pwm_raw = (count[g] < cmp[g]);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl[g]   <= tcpwm_pkg::CTRL_RST;
          period[g] <= tcpwm_pkg::PERIOD_RST;
          cmp[g]    <= tcpwm_pkg::CMP_RST;
          dead[g]   <= tcpwm_pkg::DEAD_RST;
        end else if (sel_w) begin
          case (reg_off)
            tcpwm_pkg::OFF_CTRL:   ctrl[g]   <= pwdata[tcpwm_pkg::CTRL_W-1:0];
            tcpwm_pkg::OFF_PERIOD: period[g] <= pwdata[W-1:0];
            tcpwm_pkg::OFF_CMP:    cmp[g]    <= pwdata[W-1:0];
            tcpwm_pkg::OFF_DEAD:   dead[g]   <= pwdata[7:0];
            default: ;
          endcase
        end
      end

      // Counter: a write of the enable bit starts a run from zero
      // Writing the control word always restarts from zero, so software
      // that only changes a kill level also restarts the period; that is
      // traded for a simple, glitch-free start without a separate strobe.
      // A one-shot run leaves the count standing at the period value,
      // which lets software read back where it stopped.
      // A direct write of the count word wins over counting that cycle.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          count[g]   <= '0;
          running[g] <= 1'b0;
        end else if (sel_w && reg_off == tcpwm_pkg::OFF_CTRL) begin
          running[g] <= pwdata[tcpwm_pkg::CTRL_EN];
          count[g]   <= '0;
        end else if (sel_w && reg_off == tcpwm_pkg::OFF_COUNT) begin
          count[g]   <= pwdata[W-1:0];
        end else if (running[g]) begin
          if (count[g] == period[g]) begin
            if (ctrl[g][tcpwm_pkg::CTRL_ONE]) begin
              running[g] <= 1'b0;
            end else begin
              count[g]   <= '0;
            end
          end else begin
            count[g] <= count[g] + 16'h0001;
          end
        end
      end

      // Capture flag: a new event wins over a clear in the same cycle
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          capt[g]      <= '0;
          capt_flag[g] <= 1'b0;
          cap_prev[g]  <= 1'b0;
        end else begin
          cap_prev[g] <= capture_in[g];
          if (cap_evt) begin
            capt[g]      <= count[g];
            capt_flag[g] <= 1'b1;
          end else if (sel_w && reg_off == tcpwm_pkg::OFF_STAT && pwdata[0]) begin
            capt_flag[g] <= 1'b0;
          end
        end
      end

      // Dead band: count from each edge of the raw PWM, hold rising edges until it expires
      // Both outputs are registered so the switches never see a glitch
      // from the compare logic. A rising edge waits dead+2 cycles after
      // the raw edge and a falling edge follows one cycle after it, so
      // the side being switched off always leads the side switched on.
      // A dead band longer than the raw high or low time swallows that
      // pulse entirely; software must keep the band below the duty.
      // The complement is held low while stopped so an idle bridge
      // keeps its lower switch open.
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          raw_prev  <= 1'b0;
          dt_cnt    <= 8'h00;
          dly_true  <= 1'b0;
          dly_compl <= 1'b0;
        end else begin
          raw_prev <= pwm_raw;
          if (pwm_raw != raw_prev) begin
            dt_cnt <= dead[g];
          end else if (dt_cnt != 8'h00) begin
            dt_cnt <= dt_cnt - 8'h01;
          end
          dly_true  <= pwm_raw && (pwm_raw == raw_prev) && (dt_cnt == 8'h00);
          dly_compl <= !pwm_raw && (pwm_raw == raw_prev) && (dt_cnt == 8'h00)
                       && running[g];
        end
      end

      // Kill acts combinationally so the switches open without a clock edge
      // The kill pin must be glitch free: any pulse on it reaches the
      // outputs, since there is deliberately no filter in the way.
      always_comb begin
        if (kill_in[g]) begin
          pwm_out[g].line       = ctrl[g][tcpwm_pkg::CTRL_KLVL];
          pwm_out[g].line_compl = ctrl[g][tcpwm_pkg::CTRL_KLVLC];
        end else begin
          pwm_out[g].line       = dly_true;
          pwm_out[g].line_compl = dly_compl;
        end
      end
    end
  endgenerate

  // Read data is loaded in the setup cycle and stands through the
  // access cycle, so it comes from a flip-flop and not from the mux.
  // Status shows the live kill pin, the running bit and the capture
  // flag; the count word is a snapshot taken one cycle before the
  // access edge, which software must allow for when it polls a run.
  // Unused upper bits always read zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && ch_ok) begin
      case (reg_off)
        tcpwm_pkg::OFF_CTRL:   prdata <= {27'h0, ctrl[ch_sel]};
        tcpwm_pkg::OFF_PERIOD: prdata <= {16'h0, period[ch_sel]};
        tcpwm_pkg::OFF_CMP:    prdata <= {16'h0, cmp[ch_sel]};
        tcpwm_pkg::OFF_DEAD:   prdata <= {24'h0, dead[ch_sel]};
        tcpwm_pkg::OFF_COUNT:  prdata <= {16'h0, count[ch_sel]};
        tcpwm_pkg::OFF_CAPT:   prdata <= {16'h0, capt[ch_sel]};
        tcpwm_pkg::OFF_STAT:   prdata <= {29'h0, kill_in[ch_sel], running[ch_sel],
                                          capt_flag[ch_sel]};
        default:               prdata <= 32'h0000_0000;
      endcase
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
    end
  end
endmodule // tcpwm_unit

// *** dv/tcpwm_chk.sv ***
// Checker: APB replies and channel 0 output pair of the timer unit.
// Assumes it is bound to the unit's top ports.
`timescale 1ns/1ps
module tcpwm_chk (
  input wire logic                         pclk,    // Clock
  input wire logic                         presetn, // Reset, active low
  input wire logic                         psel,    // APB select
  input wire logic                         penable, // APB access
  input wire logic                         pwrite,  // APB write
  input wire logic [11:0]                  paddr,   // APB address
  input wire logic [31:0]                  pwdata,  // APB write data
  input wire logic [31:0]                  prdata,  // APB read data
  input wire logic                         pready,  // APB ready
  input wire logic                         pslverr, // APB error
  input wire logic [4:0]                   kill_in, // Kill inputs
  input wire tcpwm_pkg::tcpwm_pair_s [4:0] pwm_out  // Output pairs
);
  logic [1:0] klvl;
  logic       en0;
  // Shadow of channel 0 control, the only one whose levels are watched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      klvl <= 2'h0;
      en0  <= 1'h0;
    end else if (psel && penable && pwrite && paddr == 12'h000) begin
      klvl <= {pwdata[3], pwdata[4]};
      en0  <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && penable; endsequence
  sequence s_bad; s_acc ##0 (paddr[11:8] != 4'h0 || paddr[7:5] > 3'h4); endsequence
  sequence s_off; !en0 [*3]; endsequence
  property p_rdy; s_acc |-> pready; endproperty
  property p_errph; pslverr |-> psel && penable; endproperty
  property p_unmap; s_bad |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  property p_map; s_acc ##0 paddr == 12'h000 |-> !pslverr; endproperty
  property p_kill; kill_in[0] |-> pwm_out[0] == klvl; endproperty
  property p_gap; !kill_in[0] |-> !(pwm_out[0].line && pwm_out[0].line_compl); endproperty
  property p_dead;
    !kill_in[0] && $past(!kill_in[0]) && $rose(pwm_out[0].line) |-> $past(!pwm_out[0].line_compl);
  endproperty
  property p_idle; s_off ##0 !kill_in[0] |-> !pwm_out[0].line_compl; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  a_errph: assert property (p_errph) else $error("pslverr outside access");
  a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
  a_map: assert property (p_map) else $error("mapped access refused");
  a_kill: assert property (p_kill) else $error("kill level wrong");
  a_gap: assert property (p_gap) else $error("pair overlaps");
  a_dead: assert property (p_dead) else $error("line rose beside compl");
  a_idle: assert property (p_idle) else $error("compl high while idle");
endmodule // tcpwm_chk

// *** dv/tcpwm_load.sv ***
// Model of a half-bridge whose two switches take one output pair.
// Assumes the pair and kill are synchronous to pclk.
`timescale 1ns/1ps
module tcpwm_load (
  input wire logic                  pclk,  // Clock
  input wire tcpwm_pkg::tcpwm_pair_s pair, // Gate drives
  input wire logic                  kill,  // Kill in force
  output int                        shorts // Shoot-through cycles
);
  initial shorts = 0;
  // Both switches on shorts the supply
  always @(posedge pclk) if (!kill && pair.line && pair.line_compl) shorts++;
endmodule // tcpwm_load

// *** dv/tcpwm_unit_tb.sv ***
// Testbench for the five-channel timer unit, APB master and pin stimulus.
// Assumes a 100 MHz clock and waits on pready for every transfer.
`timescale 1ns/1ps
module tcpwm_unit_tb;
  logic                         pclk = 1'h0;
  logic                         presetn = 1'h0;
  logic                         psel = 1'h0;
  logic                         penable = 1'h0;
  logic                         pwrite = 1'h0;
  logic [11:0]                  paddr = 12'h000;
  logic [31:0]                  pwdata = 32'h0;
  logic [31:0]                  prdata, q;
  logic                         pready, pslverr, e;
  logic [4:0]                   capture_in = 5'h00;
  logic [4:0]                   kill_in = 5'h00;
  tcpwm_pkg::tcpwm_pair_s [4:0] pwm_out;
  int                           miscompares = 0, total_checks = 0, shorts [5];
  always #5 pclk = ~pclk;
  tcpwm_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_in(capture_in), .kill_in(kill_in), .pwm_out(pwm_out));
  for (genvar g = 0; g < 5; g++) begin : g_ld
    tcpwm_load u_ld (.pclk(pclk), .pair(pwm_out[g]), .kill(kill_in[g]), .shorts(shorts[g]));
  end
  function logic [11:0] ad(int n, logic [4:0] o);
    return 12'(n) * tcpwm_pkg::CH_STRIDE + {7'h0, o};
  endfunction
  task chk(input string n, input logic [31:0] x, input logic [31:0] y);
    total_checks++;
    if (x !== y) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", n, x, y);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task t_reset;
    xfer(0, ad(0, tcpwm_pkg::OFF_CTRL), 0);
    chk("ctrl", 32'(tcpwm_pkg::CTRL_RST), q);
    xfer(0, ad(0, tcpwm_pkg::OFF_PERIOD), 0);
    chk("period", 32'(tcpwm_pkg::PERIOD_RST), q);
    $display("t_reset done");
  endtask
  task t_pwm;
    int hl, hc;
    // Period 16, compare 6, dead band n: line 5-n cycles, compl 9-n
    for (int n = 0; n < 5; n++) begin
      xfer(1, ad(n, tcpwm_pkg::OFF_PERIOD), 32'd15);
      xfer(1, ad(n, tcpwm_pkg::OFF_CMP), 32'd6);
      xfer(1, ad(n, tcpwm_pkg::OFF_DEAD), 32'(n));
      xfer(1, ad(n, tcpwm_pkg::OFF_CTRL), 32'h1);
      repeat (20) @(posedge pclk);
      hl = 0;
      hc = 0;
      repeat (16) begin
        @(negedge pclk);
        hl += int'(pwm_out[n].line === 1'h1);
        hc += int'(pwm_out[n].line_compl === 1'h1);
      end
      chk("line high", 32'(5 - n), 32'(hl));
      chk("compl high", 32'(9 - n), 32'(hc));
      xfer(1, ad(n, tcpwm_pkg::OFF_CTRL), 32'h0);
    end
    $display("t_pwm done");
  endtask
  task t_shot;
    xfer(1, ad(0, tcpwm_pkg::OFF_PERIOD), 32'd7);
    xfer(1, ad(0, tcpwm_pkg::OFF_CTRL), 32'h7);
    repeat (20) @(posedge pclk);
    xfer(0, ad(0, tcpwm_pkg::OFF_COUNT), 0);
    chk("stopped count", 32'd7, q);
    capture_in <= 5'h01;
    @(posedge pclk);
    capture_in <= 5'h00;
    xfer(0, ad(0, tcpwm_pkg::OFF_CAPT), 0);
    chk("capture", 32'd7, q);
    xfer(0, ad(0, tcpwm_pkg::OFF_STAT), 0);
    chk("status flag set", 32'h1, q);
    xfer(1, ad(0, tcpwm_pkg::OFF_STAT), 32'h1);
    xfer(0, ad(0, tcpwm_pkg::OFF_STAT), 0);
    chk("status flag clear", 32'h0, q);
    xfer(1, ad(0, tcpwm_pkg::OFF_COUNT), 32'd2);
    xfer(0, ad(0, tcpwm_pkg::OFF_COUNT), 0);
    chk("count write", 32'd2, q);
    $display("t_shot done");
  endtask
  task t_kill;
    for (int k = 0; k < 2; k++) begin
      xfer(1, ad(0, tcpwm_pkg::OFF_CTRL), k ? 32'h11 : 32'h09);
      kill_in <= 5'h01;
      @(negedge pclk);
      chk("kill pair", k ? 32'h1 : 32'h2, 32'(pwm_out[0]));
      @(posedge pclk);
      kill_in <= 5'h00;
    end
    xfer(0, 12'h0a0, 0);
    chk("unmapped err", 32'h1, 32'(e));
    chk("unmapped data", 32'h0, q);
    $display("t_kill done");
  endtask
  task give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_pwm();
    t_shot();
    t_kill();
    for (int n = 0; n < 5; n++) chk("shorts", 32'h0, 32'(shorts[n]));
    give_verdict();
  end
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
endmodule // tcpwm_unit_tb
bind tcpwm_unit tcpwm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .kill_in(kill_in), .pwm_out(pwm_out));
